/* logic/adc_ctrl_pkg.sv */
// Package for the converter control block: register indices, field positions, reset values and timing.
// Assumes a 32-bit Avalon-MM slave whose word address equals the register index.
`default_nettype none
package adc_ctrl_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [3:0] IDX_CONTROL_A = 4'h0;
    localparam logic [3:0] IDX_REFERENCE_CONTROL = 4'h1;
    localparam logic [3:0] IDX_CONTROL_B = 4'h2;
    localparam logic [3:0] IDX_INPUT_CONTROL = 4'h3;
    localparam logic [3:0] IDX_STATUS = 4'h5;
    localparam logic [3:0] IDX_DEBUG_CONTROL = 4'h6;
    localparam logic [3:0] IDX_LATENCY = 4'h7;
    localparam logic [7:0] IDX_EVENT_CONTROL = 8'h14;
    // Field positions.
    localparam int CA_SOFT_RESET = 0;
    localparam int CA_ENABLE = 1;
    localparam int CA_RUN_STANDBY = 2;
    localparam int RC_COMP = 7;
    localparam int CB_FREE_RUN = 0;
    localparam int CB_DIFF = 1;
    localparam int CB_RES_LO = 4;
    localparam int IC_GAIN_LO = 8;
    // Reset values.
    localparam logic [7:0] RST_REFERENCE_CONTROL = 8'h00;
    localparam logic [7:0] RST_EVENT_CONTROL = 8'h00;
    localparam logic [1:0] RST_RESOLUTION = 2'h0;
    localparam logic [4:0] RST_POSITIVE_INPUT_SELECT = 5'h00;
    localparam logic [3:0] RST_GAIN = 4'h0;
    // Resolution codes.
    localparam logic [1:0] RES_12 = 2'h0;
    localparam logic [1:0] RES_10 = 2'h1;
    localparam logic [1:0] RES_8 = 2'h2;
    // Gain codes that are not reserved.
    localparam logic [3:0] GAIN_1X = 4'h0;
    localparam logic [3:0] GAIN_2X = 4'h1;
    localparam logic [3:0] GAIN_4X = 4'h2;
    localparam logic [3:0] GAIN_8X = 4'h3;
    localparam logic [3:0] GAIN_16X = 4'h4;
    localparam logic [3:0] GAIN_HALF = 4'hF;
    // Positive input ranges.
    localparam logic [4:0] MUX_PIN_FIRST = 5'h03;
    localparam logic [4:0] MUX_PIN_LAST = 5'h13;
    localparam logic [4:0] MUX_INT_FIRST = 5'h18;
    localparam logic [4:0] MUX_INT_LAST = 5'h1C;
    // Synchronisation delay of enable and soft reset, in clock cycles.
    localparam int SYNC_CYCLES_DEFAULT = 4;

    // One bus request as the master presents it.
    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } avmm_req_s;
endpackage : adc_ctrl_pkg
`default_nettype wire

/* logic/adc_conversion_control.sv */
// Converter control block: registers over Avalon-MM, enable and soft reset synchronisation, latency timing.
// Assumes one 10 MHz clock, where one clock cycle stands for half a converter-clock period.
//
// Operation
// RULE_01: Latency is 1 + resolution/2 + gain delay single-shot; resolution/2 + gain delay free-running.
// RULE_02: Gain delay follows the per-mode, per-input-type table; codes 0x5 to 0xE reserved.
// RULE_03: Three resolutions, 8, 10 and 12 bits, chosen in control_b.
// RULE_04: Resolution selects twelve bits after reset.
// RULE_05: Run-in-standby bit: 0 halts the converter in standby, 1 keeps it running.
// RULE_06: Enable reads back at once, sets sync_pending, which clears when enable takes effect.
// RULE_07: Writing soft_reset one resets all registers but debug_control and disables; zero does nothing.
// RULE_08: A write that sets soft_reset discards every other change in that write.
// RULE_09: Soft_reset reads one while busy; it and sync_pending clear when reset finishes.
// RULE_10: Reference control bit 7 enables buffer offset compensation; resets to zero.
// RULE_11: Reference control bits 3:0 select the voltage reference.
// RULE_12: Five-bit positive input select: pins 3 to 19, internal sources 0x18 to 0x1C, rest reserved.
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control #(
    parameter int SYNC_CYCLES = adc_ctrl_pkg::SYNC_CYCLES_DEFAULT
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Avalon-MM slave.
    input wire adc_ctrl_pkg::avmm_req_s bus_req_in,
    output logic [31:0] bus_readdata_out,
    output logic bus_waitrequest_out,
    // System standby pin and conversion trigger.
    input wire logic standby_in,
    input wire logic conv_start_in,
    // Converter controls.
    output logic converter_enabled_out,
    output logic converter_running_out,
    output logic [3:0] ref_source_select_out,
    output logic ref_offset_comp_en_out,
    output logic [4:0] positive_input_select_out,
    output logic positive_input_valid_out,
    output logic [1:0] resolution_select_out,
    output logic [5:0] latency_half_out,
    output logic result_ready_out
);

    // The block runs on one clock. Each
    // cycle of it stands for half of a
    // converter-clock period, so every
    // latency below is kept in half
    // periods and the half-period gain
    // delays need no fraction.
    // Software sees only the bus; the
    // converter sees the enable, the
    // selects and the result strobe.
    // Control state.
    logic enable_reg, enable_next;
    logic enable_active_reg;
    logic run_standby_reg, run_standby_next;
    logic soft_reset_reg;
    logic sync_pending_reg;
    logic [7:0] sync_count_reg;
    logic [7:0] reference_control_reg, reference_control_next;
    logic [7:0] event_control_reg, event_control_next;
    logic [7:0] debug_control_reg;
    logic free_run_reg, diff_reg;
    logic [1:0] resolution_select_reg;
    logic [4:0] positive_input_select_reg;
    logic [3:0] gain_reg;

    // Bus handshake state.
    logic wait_reg;
    logic [31:0] readdata_reg;

    // Standby synchroniser and filtered level.
    logic stby_s1_reg, stby_s2_reg, stby_s3_reg, standby_reg;

    // Conversion timer.
    logic [5:0] conv_count_reg;
    logic result_ready_reg;
    logic running_reg;
    logic [5:0] latency_reg;
    logic mux_valid_reg;

    // Decoding: a request is served at the edge where waitrequest is seen low.
    wire take_w = (bus_req_in.read | bus_req_in.write) & ~wait_reg;
    wire wr_w = take_w & bus_req_in.write;
    wire be0_w = bus_req_in.byteenable[0];
    wire be1_w = bus_req_in.byteenable[1];
    wire be3_w = bus_req_in.byteenable[3];
    wire sel_ca_w = bus_req_in.address == {4'h0, adc_ctrl_pkg::IDX_CONTROL_A};
    wire sel_rc_w = bus_req_in.address == {4'h0, adc_ctrl_pkg::IDX_REFERENCE_CONTROL};
    wire sel_cb_w = bus_req_in.address == {4'h0, adc_ctrl_pkg::IDX_CONTROL_B};
    wire sel_ic_w = bus_req_in.address == {4'h0, adc_ctrl_pkg::IDX_INPUT_CONTROL};
    wire sel_st_w = bus_req_in.address == {4'h0, adc_ctrl_pkg::IDX_STATUS};
    wire sel_dc_w = bus_req_in.address == {4'h0, adc_ctrl_pkg::IDX_DEBUG_CONTROL};
    wire sel_lt_w = bus_req_in.address == {4'h0, adc_ctrl_pkg::IDX_LATENCY};
    wire sel_ev_w = bus_req_in.address == adc_ctrl_pkg::IDX_EVENT_CONTROL;
    wire [31:0] wd_w = bus_req_in.writedata;
    // A soft reset request swallows the rest of its own write.
    wire srst_req_w = wr_w & sel_ca_w & be0_w & wd_w[adc_ctrl_pkg::CA_SOFT_RESET]; // RULE_07
    wire plain_wr_w = wr_w & ~srst_req_w; // RULE_08
    wire en_wr_w = plain_wr_w & sel_ca_w & be0_w;
    wire sync_done_w = sync_pending_reg & (sync_count_reg == 8'h01);
    wire srst_done_w = sync_done_w & soft_reset_reg; // RULE_09
    // Every register except debug control, the bus handshake and the standby flops is cleared by either reset.
    wire clear_w = ~rst_n_in | srst_done_w; // RULE_07

    // Byte lanes matter: only lane 0
    // carries the control bits, and
    // lane 1 carries the gain code. A
    // write with lane 0 off leaves the
    // control bits as they were.

    // Next values of software fields, gated by select and byte lane.
    assign enable_next = en_wr_w ? wd_w[adc_ctrl_pkg::CA_ENABLE] : enable_reg; // RULE_06
    assign run_standby_next = en_wr_w ? wd_w[adc_ctrl_pkg::CA_RUN_STANDBY] : run_standby_reg; // RULE_05
    assign reference_control_next = (plain_wr_w & sel_rc_w & be0_w)
        ? (wd_w[7:0] & 8'h8F) : reference_control_reg; // RULE_10 RULE_11
    assign event_control_next = (plain_wr_w & sel_ev_w & be0_w) ? wd_w[7:0] : event_control_reg;

    // The gain table is kept in half
    // periods so that the half-period
    // entries stay exact integers.

    // Gain delay in half converter-clock periods, single-ended single-shot adding one period.
    function automatic logic [2:0] gain_half(input logic [3:0] gain, input logic free, input logic diff);
        logic [2:0] base;
        base = 3'h0;
        unique case (gain)
            adc_ctrl_pkg::GAIN_1X: base = free ? (diff ? 3'h0 : 3'h0) : 3'h0;
            adc_ctrl_pkg::GAIN_2X: base = free ? (diff ? 3'h0 : 3'h2) : 3'h1;
            adc_ctrl_pkg::GAIN_4X: base = 3'h2;
            adc_ctrl_pkg::GAIN_8X: base = free ? (diff ? 3'h2 : 3'h4) : 3'h3;
            adc_ctrl_pkg::GAIN_16X: base = 3'h4;
            adc_ctrl_pkg::GAIN_HALF: base = free ? (diff ? 3'h0 : 3'h2) : 3'h1;
            default: base = 3'h0; // Reserved codes add nothing.
        endcase
        if (!free && !diff) begin
            base = base + 3'h2;
        end
        return base; // RULE_02
    endfunction : gain_half


    // A reserved resolution code acts
    // as twelve bits, the safest case.
    // Resolution in half periods equals the bit count; reserved code behaves as twelve bits.
    wire [5:0] res_half_w = (resolution_select_reg == adc_ctrl_pkg::RES_10) ? 6'h0A
        : (resolution_select_reg == adc_ctrl_pkg::RES_8) ? 6'h08 : 6'h0C; // RULE_03
    wire [5:0] lat_w = res_half_w + {3'h0, gain_half(gain_reg, free_run_reg, diff_reg)}
        + (free_run_reg ? 6'h00 : 6'h02); // RULE_01
    wire mux_ok_w = ((positive_input_select_reg >= adc_ctrl_pkg::MUX_PIN_FIRST)
        && (positive_input_select_reg <= adc_ctrl_pkg::MUX_PIN_LAST))
        || ((positive_input_select_reg >= adc_ctrl_pkg::MUX_INT_FIRST)
        && (positive_input_select_reg <= adc_ctrl_pkg::MUX_INT_LAST)); // RULE_12
    wire run_w = enable_active_reg & ~(standby_reg & ~run_standby_reg); // RULE_05
    wire start_w = run_w & (conv_count_reg == 6'h00) & (free_run_reg | conv_start_in);

    // Read multiplexer; unmapped words read zero.
    wire [31:0] rd_w = sel_ca_w ? {29'h0, run_standby_reg, enable_reg, soft_reset_reg}
        : sel_rc_w ? {24'h0, reference_control_reg}
        : sel_cb_w ? {26'h0, resolution_select_reg, 2'h0, diff_reg, free_run_reg}
        : sel_ic_w ? {20'h0, gain_reg, 3'h0, positive_input_select_reg}
        : sel_st_w ? {31'h0, sync_pending_reg}
        : sel_dc_w ? {24'h0, debug_control_reg}
        : sel_lt_w ? {26'h0, latency_reg}
        : sel_ev_w ? {24'h0, event_control_reg} : 32'h0;

    // Each access waits exactly one
    // cycle. The simple fixed wait keeps
    // the master's view plain, at the
    // cost of half the peak bus rate.
    // Read data is registered from the
    // mux one edge early, so it already
    // stands when waitrequest is low.
    // A master that drops its request
    // early leaves waitrequest low for
    // one idle cycle, which is harmless
    // because no access is then taken.

    // Bus handshake: waitrequest drops for one cycle per request, so every access takes two edges.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wait_reg <= 1'b1;
            readdata_reg <= 32'h0;
        end else begin
            wait_reg <= ~((bus_req_in.read | bus_req_in.write) & wait_reg);
            readdata_reg <= rd_w;
        end
    end

    // The standby level is a pin from
    // the system, hence three flops; a
    // one-cycle glitch never reaches
    // the halt logic.

    // Standby pin passes three flops; a change counts once the last two agree.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            stby_s1_reg <= 1'b0;
            stby_s2_reg <= 1'b0;
            stby_s3_reg <= 1'b0;
            standby_reg <= 1'b0;
        end else begin
            stby_s1_reg <= standby_in;
            stby_s2_reg <= stby_s1_reg;
            stby_s3_reg <= stby_s2_reg;
            if (stby_s2_reg == stby_s3_reg) begin
                standby_reg <= stby_s3_reg;
            end
        end
    end

    // Debug control is kept apart from
    // the clear net on purpose, so a
    // debug session keeps its settings
    // across a soft reset.

    // Debug control survives a soft reset and only sees the pin reset.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            debug_control_reg <= 8'h00;
        end else if (plain_wr_w & sel_dc_w & be0_w) begin
            debug_control_reg <= {7'h0, wd_w[0]};
        end
    end

    // Plain configuration registers.
    always_ff @(posedge clk_in) begin
        if (clear_w) begin
            run_standby_reg <= 1'b0;
            reference_control_reg <= adc_ctrl_pkg::RST_REFERENCE_CONTROL; // RULE_10
            event_control_reg <= adc_ctrl_pkg::RST_EVENT_CONTROL;
            free_run_reg <= 1'b0;
            diff_reg <= 1'b0;
            resolution_select_reg <= adc_ctrl_pkg::RST_RESOLUTION; // RULE_04
            positive_input_select_reg <= adc_ctrl_pkg::RST_POSITIVE_INPUT_SELECT;
            gain_reg <= adc_ctrl_pkg::RST_GAIN;
        end else begin
            run_standby_reg <= run_standby_next;
            reference_control_reg <= reference_control_next;
            event_control_reg <= event_control_next;
            if (plain_wr_w & sel_cb_w & be0_w) begin
                free_run_reg <= wd_w[adc_ctrl_pkg::CB_FREE_RUN];
                diff_reg <= wd_w[adc_ctrl_pkg::CB_DIFF];
                resolution_select_reg <= wd_w[adc_ctrl_pkg::CB_RES_LO +: 2]; // RULE_03
            end
            if (plain_wr_w & sel_ic_w & be0_w) begin
                positive_input_select_reg <= wd_w[4:0]; // RULE_12
            end
            if (plain_wr_w & sel_ic_w & be1_w) begin
                gain_reg <= wd_w[adc_ctrl_pkg::IC_GAIN_LO +: 4];
            end
        end
    end

    // Hazard: a soft reset and an enable
    // share one counter. The soft reset
    // wins in its own cycle, and once it
    // completes it clears the enable as
    // well, so software must write the
    // enable again afterwards.
    // While sync_pending is high, the
    // enable read back may differ from
    // the converter's state; software
    // should poll status before it
    // relies on the converter.

    // Enable and soft reset synchronisation; the counter models the crossing into the converter domain.
    // A later write restarts the count; the last enable written takes effect, but a pending soft reset still wins and clears it.
    always_ff @(posedge clk_in) begin
        if (clear_w) begin
            enable_reg <= 1'b0;
            enable_active_reg <= 1'b0;
            soft_reset_reg <= 1'b0; // RULE_09
            sync_pending_reg <= 1'b0; // RULE_09
            sync_count_reg <= 8'h00;
        end else if (srst_req_w) begin
            soft_reset_reg <= 1'b1; // RULE_07
            sync_pending_reg <= 1'b1;
            sync_count_reg <= 8'(SYNC_CYCLES);
        end else if (en_wr_w) begin
            enable_reg <= enable_next; // RULE_06
            sync_pending_reg <= 1'b1; // RULE_06
            sync_count_reg <= 8'(SYNC_CYCLES);
        end else if (sync_pending_reg) begin
            sync_count_reg <= sync_count_reg - 8'h01;
            if (sync_done_w) begin
                enable_active_reg <= enable_reg; // RULE_06
                sync_pending_reg <= 1'b0; // RULE_06
            end
        end
    end

    // A start is taken only when the
    // timer is idle, so a start pulse
    // during a conversion is lost. A
    // change of mode or gain in flight
    // takes effect at the next start,
    // because the count is loaded once.
    // Leaving run state clears the
    // count, so a halted conversion
    // never flags a stale result.

    // Conversion timer: counts the latency in half periods, then flags a result.
    // In free-running mode the next conversion starts the cycle after the previous ends.
    always_ff @(posedge clk_in) begin
        if (clear_w) begin
            conv_count_reg <= 6'h00;
            result_ready_reg <= 1'b0;
            running_reg <= 1'b0;
            latency_reg <= 6'h00;
            mux_valid_reg <= 1'b0;
        end else begin
            running_reg <= run_w;
            latency_reg <= lat_w; // RULE_01
            mux_valid_reg <= mux_ok_w;
            result_ready_reg <= run_w & (conv_count_reg == 6'h01);
            if (!run_w) begin
                conv_count_reg <= 6'h00;
            end else if (start_w) begin
                conv_count_reg <= lat_w; // RULE_01
            end else if (conv_count_reg != 6'h00) begin
                conv_count_reg <= conv_count_reg - 6'h01;
            end
        end
    end

    // The outputs are plain flop
    // copies, so the converter side
    // sees no decode glitches.

    // Every output comes straight from a flop.
    assign bus_readdata_out = readdata_reg;
    assign bus_waitrequest_out = wait_reg;
    assign converter_enabled_out = enable_active_reg;
    assign converter_running_out = running_reg;
    assign ref_source_select_out = reference_control_reg[3:0]; // RULE_11
    assign ref_offset_comp_en_out = reference_control_reg[adc_ctrl_pkg::RC_COMP]; // RULE_10
    assign positive_input_select_out = positive_input_select_reg;
    assign positive_input_valid_out = mux_valid_reg;
    assign resolution_select_out = resolution_select_reg;
    assign latency_half_out = latency_reg;
    assign result_ready_out = result_ready_reg;
endmodule : adc_conversion_control
`default_nettype wire

/* tb/adc_ctrl_assertions.sv */
// Checker for the converter control block: reset values, sync delays, soft reset, input select.
// Assumes a bind onto adc_conversion_control with SYNC_CYCLES of 2 to 7.
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_assertions (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Watched ports.
    input wire adc_ctrl_pkg::avmm_req_s bus_req_in,
    input wire logic bus_waitrequest_out,
    input wire logic converter_enabled_out,
    input wire logic converter_running_out,
    input wire logic ref_offset_comp_en_out,
    input wire logic [3:0] ref_source_select_out,
    input wire logic [4:0] positive_input_select_out,
    input wire logic positive_input_valid_out,
    input wire logic [1:0] resolution_select_out,
    input wire logic result_ready_out
);
    // Accepted control_a writes, decoded once so every property sees the same acceptance edge.
    wire logic ctl_wr = bus_req_in.write && !bus_waitrequest_out && bus_req_in.address == 8'h00;
    wire logic sr_wr = ctl_wr && bus_req_in.byteenable[0] && bus_req_in.writedata[0];
    wire logic en_wr = ctl_wr && bus_req_in.byteenable[0] && bus_req_in.writedata[1:0] == 2'h2;
    wire logic [4:0] sel = positive_input_select_out;
    wire logic mux_ok = (sel >= 5'h03 && sel <= 5'h13) || (sel >= 5'h18 && sel <= 5'h1C);

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // Enable may not act at once; it must land inside the bounded sync window.
    sequence s_sync_wait;
        !converter_enabled_out [*2] ##[1:6] converter_enabled_out;
    endsequence
    property p_enable_sync;
        en_wr && !converter_enabled_out |=> s_sync_wait;
    endproperty
    a_enable_sync: assert property (p_enable_sync) else $error("enable timing wrong");
    property p_soft_reset;
        sr_wr |-> ##[1:8] (!converter_enabled_out && ref_source_select_out == 4'h0 && !ref_offset_comp_en_out);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");
    property p_discard;
        sr_wr && !converter_enabled_out |=> !converter_enabled_out [*8];
    endproperty
    a_discard: assert property (p_discard) else $error("enable kept in reset write");
    property p_res_reset;
        $rose(rst_n_in) |-> resolution_select_out == adc_ctrl_pkg::RES_12;
    endproperty
    a_res_reset: assert property (p_res_reset) else $error("resolution not 12 bit");
    property p_comp_reset;
        $rose(rst_n_in) |-> !ref_offset_comp_en_out;
    endproperty
    a_comp_reset: assert property (p_comp_reset) else $error("compensation set at reset");
    property p_mux_valid;
        $past(rst_n_in) |-> positive_input_valid_out == $past(mux_ok);
    endproperty
    a_mux_valid: assert property (p_mux_valid) else $error("input valid wrong");
    property p_ready_pulse;
        result_ready_out |=> !result_ready_out;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
    property p_running;
        !converter_enabled_out [*2] |-> !converter_running_out;
    endproperty
    a_running: assert property (p_running) else $error("running while disabled");
endmodule : adc_ctrl_assertions
bind adc_conversion_control adc_ctrl_assertions u_checker (.clk_in, .rst_n_in, .bus_req_in, .bus_waitrequest_out,
    .converter_enabled_out, .converter_running_out, .ref_offset_comp_en_out, .ref_source_select_out,
    .positive_input_select_out, .positive_input_valid_out, .resolution_select_out, .result_ready_out);
`default_nettype wire

/* tb/adc_conversion_control_tb.sv */
// Testbench for the converter control block: registers, latency table, input select, enable, soft reset.
// Assumes the package and block are compiled first; one 10 MHz clock, bus driven from here.
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_tb;
    logic clk_in = 1'h0;
    logic rst_n_in = 1'h0;
    adc_ctrl_pkg::avmm_req_s bus_req_in = '0;
    logic standby_in = 1'h0;
    logic conv_start_in = 1'h0;
    logic [31:0] bus_readdata_out, q;
    logic bus_waitrequest_out, converter_enabled_out, converter_running_out, ref_offset_comp_en_out;
    logic positive_input_valid_out, result_ready_out;
    logic [3:0] ref_source_select_out;
    logic [4:0] positive_input_select_out;
    logic [1:0] resolution_select_out;
    logic [5:0] latency_half_out;
    int fail_count = 0;
    int num_checks = 0;
    int n;
    // Six sync cycles leave room to read the pending state back.
    adc_conversion_control #(.SYNC_CYCLES(6)) dut (.clk_in, .rst_n_in, .bus_req_in, .bus_readdata_out,
        .bus_waitrequest_out, .standby_in, .conv_start_in, .converter_enabled_out, .converter_running_out,
        .ref_source_select_out, .ref_offset_comp_en_out, .positive_input_select_out,
        .positive_input_valid_out, .resolution_select_out, .latency_half_out, .result_ready_out);
    // Clock of 100 ns period.
    initial forever #50 clk_in = ~clk_in;
    // Counts a comparison and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One transfer held until waitrequest is sampled low; read data is taken at that edge.
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_in);
        bus_req_in <= '{read: !wr, write: wr, address: idx, byteenable: 4'hF, writedata: d};
        do begin
            @(posedge clk_in);
            k++;
        end while (bus_waitrequest_out !== 1'h0 && k < 20);
        q = bus_readdata_out;
        bus_req_in <= '0;
        chk(k < 20, 1'h1);
    endtask : xfer
    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    // Reset values and an unmapped index, which must read zero after a write.
    task automatic test_reset();
        xfer(1'h0, 8'h01, '0);
        chk(q, 32'h0);
        xfer(1'h0, 8'h02, '0);
        chk(q[5:4], adc_ctrl_pkg::RES_12);
        xfer(1'h0, 8'h07, '0);
        chk(q[5:0], 6'h10);
        xfer(1'h0, 8'h14, '0);
        chk(q, 32'h0);
        xfer(1'h1, 8'h04, 32'hFF);
        xfer(1'h0, 8'h04, '0);
        chk(q, 32'h0);
        $display("test_reset done");
    endtask : test_reset
    // Every positive input code, reserved ones included.
    task automatic test_mux();
        for (int i = 0; i < 32; i++) begin
            xfer(1'h1, 8'h03, 32'(i));
            repeat (2) @(posedge clk_in);
            chk(positive_input_valid_out, (i >= 3 && i <= 19) || (i >= 24 && i <= 28));
            chk(positive_input_select_out, 32'(i));
        end
        $display("test_mux done");
    endtask : test_mux
    // Latency in half periods over every resolution, mode, input type and non-reserved gain code.
    task automatic test_latency();
        logic [3:0] gains [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hF};
        int fr_d [6] = '{0, 0, 2, 2, 4, 0};
        int fr_s [6] = '{0, 2, 2, 4, 4, 2};
        int ss_d [6] = '{0, 1, 2, 3, 4, 1};
        int e;
        for (int r = 0; r < 3; r++) begin
            for (int m = 0; m < 4; m++) begin
                xfer(1'h1, 8'h02, {26'h0, r[1:0], 2'h0, m[1:0]});
                for (int g = 0; g < 6; g++) begin
                    xfer(1'h1, 8'h03, {20'h0, gains[g], 8'h00});
                    xfer(1'h0, 8'h07, '0);
                    e = 12 - 2 * r + (m[0] ? (m[1] ? fr_d[g] : fr_s[g]) : 2 + ss_d[g] + (m[1] ? 0 : 2));
                    chk(q[5:0], 6'(e));
                    chk(latency_half_out, 6'(e));
                    chk(resolution_select_out, r[1:0]);
                end
            end
        end
        $display("test_latency done");
    endtask : test_latency
    // Enable handshake, standby halt and one single-shot conversion of 8 bits, differential, gain 1X.
    task automatic test_enable();
        xfer(1'h1, 8'h02, 32'h22);
        xfer(1'h1, 8'h03, 32'h0);
        xfer(1'h1, 8'h00, 32'h2);
        xfer(1'h0, 8'h05, '0);
        chk(q[0], 1'h1);
        xfer(1'h0, 8'h00, '0);
        chk(q[1], 1'h1);
        for (n = 0; n < 10 && converter_enabled_out !== 1'h1; n++) @(posedge clk_in);
        chk(converter_enabled_out, 1'h1);
        xfer(1'h0, 8'h05, '0);
        chk(q[0], 1'h0);
        standby_in <= 1'h1;
        repeat (8) @(posedge clk_in);
        chk(converter_running_out, 1'h0);
        xfer(1'h1, 8'h00, 32'h6);
        repeat (8) @(posedge clk_in);
        chk(converter_running_out, 1'h1);
        standby_in <= 1'h0;
        conv_start_in <= 1'h1;
        @(posedge clk_in);
        conv_start_in <= 1'h0;
        for (n = 0; n < 40 && result_ready_out !== 1'h1; n++) @(posedge clk_in);
        chk(n >= 10 && n <= 11, 1'h1);
        xfer(1'h1, 8'h00, 32'h0);
        for (n = 0; n < 10 && converter_enabled_out !== 1'h0; n++) @(posedge clk_in);
        chk(converter_enabled_out, 1'h0);
        $display("test_enable done");
    endtask : test_enable
    // Soft reset that also carries an enable; debug_control must survive it.
    task automatic test_soft_reset();
        xfer(1'h1, 8'h01, 32'h8F);
        xfer(1'h1, 8'h06, 32'h1);
        chk(ref_source_select_out, 4'hF);
        chk(ref_offset_comp_en_out, 1'h1);
        xfer(1'h1, 8'h00, 32'h0);
        xfer(1'h0, 8'h01, '0);
        chk(q, 32'h8F);
        xfer(1'h1, 8'h00, 32'h3);
        xfer(1'h0, 8'h00, '0);
        chk(q[1:0], 2'h1);
        for (n = 0; n < 10 && q[0] !== 1'h0; n++) xfer(1'h0, 8'h05, '0);
        chk(q[0], 1'h0);
        xfer(1'h0, 8'h00, '0);
        chk(q[1:0], 2'h0);
        xfer(1'h0, 8'h01, '0);
        chk(q, 32'h0);
        xfer(1'h0, 8'h02, '0);
        chk(q[5:4], adc_ctrl_pkg::RES_12);
        xfer(1'h0, 8'h06, '0);
        chk(q[0], 1'h1);
        $display("test_soft_reset done");
    endtask : test_soft_reset
    // Reset for four cycles, then the scenarios in order.
    initial begin
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1'h1;
        test_reset();
        test_mux();
        test_latency();
        test_enable();
        test_soft_reset();
        tally_and_finish();
    end
    // The scenarios need under two thousand cycles, so a hang is cut off well past that.
    initial begin
        repeat (20000) @(posedge clk_in);
        fail_count++;
        tally_and_finish();
    end
endmodule : adc_conversion_control_tb
`default_nettype wire
